// [edac_pkg.sv]
// Purpose: constants for the data store access controller
// Assumes: one clock, 10 MHz; byte-wide special-function register port
// Notes: Function
// Function
// R1: Byte store of 32 to 256 bytes, addressed from zero.
// R2: One byte per access via index, value and control registers.
// R3: Software reaches control register indirectly at 40H with bank 01H.
// R4: Index register keeps only needed low bits; upper bits read zero.
// R5: Software sets fetch_permit, then loads the index, before reading.
// R6: fetch_start with fetch_permit set starts a read cycle.
// R7: fetch_start without fetch_permit starts nothing.
// R8: Read end clears fetch_start; fetched byte then sits in value register.
// R9: Value register holds fetched byte until next read or write.
// R10: Software trusts value register only after fetch_start reads zero.
// R11: Software sets enables in an earlier access than start bits.
// R12: Software never sets fetch_start and program_start together.
// R13: program_start with program_permit launches a timed write; else nothing.
// R14: Write end clears program_start by hardware.
// R15: Power-on clears program_permit.
// R16: Each cycle end sets cell_done_flag and a request; software clears it.
// R17: Control bits: permit write 3, start write 2, permit read 1, start read 0.
// R18: Start requests during a running cycle are ignored.
package edac_pkg;
	localparam int EDAC_ADDR_W = 8;
	localparam int EDAC_DEPTH = 256;
	localparam logic [7:0] EDAC_SEL_INDEX = 8'h00;
	localparam logic [7:0] EDAC_SEL_VALUE = 8'h01;
	localparam logic [7:0] EDAC_SEL_CTRL = 8'h40;
	localparam logic [7:0] EDAC_SEL_FLAG = 8'h02;
	localparam logic [7:0] EDAC_CTRL_BANK = 8'h01;
	localparam logic [7:0] EDAC_DATA_BANK = 8'h00;
	localparam int EDAC_BIT_FSTART = 0;
	localparam int EDAC_BIT_FPERMIT = 1;
	localparam int EDAC_BIT_PSTART = 2;
	localparam int EDAC_BIT_PPERMIT = 3;
	localparam logic [7:0] EDAC_CTRL_RST = 8'h00;
	localparam logic [7:0] EDAC_BYTE_RST = 8'h00;
	localparam int EDAC_CLK_HZ = 10_000_000;
	localparam int EDAC_WRITE_US = 2;
	localparam logic [7:0] EDAC_WRITE_CYC = 8'(EDAC_WRITE_US * (EDAC_CLK_HZ / 1_000_000));
	localparam logic [7:0] EDAC_READ_CYC = 8'h02;
	typedef enum logic [1:0] {
		EDAC_IDLE = 2'b00,
		EDAC_READ = 2'b01,
		EDAC_WRITE = 2'b10
	} edac_state_t;
endpackage

// [edac_ctrl.sv]
// Purpose: byte access controller for on-chip non-volatile data store
// Assumes: core drives bank, select, write strobe and data synchronously
// Notes: store modelled as array; index width set by ADDR_W
// Notes: start bits written while a cycle runs are dropped, permits are kept
`timescale 1ns/100ps
`default_nettype none
module edac_ctrl
	import edac_pkg::*;
#(
	parameter int ADDR_W = EDAC_ADDR_W
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] bank_select_in,
	input wire logic [7:0] reg_sel_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic cell_done_flag_out,
	output logic cell_done_req_out
);
	logic [ADDR_W-1:0] cell_index_reg;
	logic [7:0] cell_value_reg;
	logic [3:0] cell_control_reg;
	logic cell_done_flag_reg;
	logic done_req_reg;
	edac_state_t state_reg;
	logic [7:0] cnt_reg;
	logic [7:0] store_mem [0:(1<<ADDR_W)-1];
	logic hit_index, hit_value, hit_ctrl, hit_flag;
	logic cycle_end, busy;
	logic read_end, write_end;
	logic rd_index, rd_value, rd_ctrl, rd_flag;
	edac_state_t state_next;
	logic [7:0] cnt_next;
	logic [ADDR_W-1:0] index_next;
	logic [3:0] control_next;
	logic [7:0] value_next;
	logic done_flag_next;
	logic [7:0] rdata_next;

	// Register selection by bank; reads and writes share one decode
	function automatic logic sel_match(input logic [7:0] bank, input logic [7:0] sel);
		sel_match = (bank_select_in == bank) && (reg_sel_in == sel);
	endfunction

	function automatic logic sel_hit(input logic [7:0] bank, input logic [7:0] sel);
		sel_hit = reg_wr_in && sel_match(bank, sel);
	endfunction

	assign hit_index = sel_hit(EDAC_DATA_BANK, EDAC_SEL_INDEX); // R2
	assign hit_value = sel_hit(EDAC_DATA_BANK, EDAC_SEL_VALUE);
	assign hit_flag = sel_hit(EDAC_DATA_BANK, EDAC_SEL_FLAG);
	assign hit_ctrl = sel_hit(EDAC_CTRL_BANK, EDAC_SEL_CTRL); // R3
	assign busy = (state_reg != EDAC_IDLE);
	assign cycle_end = busy && (cnt_reg == 8'h01);
	assign read_end = cycle_end && (state_reg == EDAC_READ);
	assign write_end = cycle_end && (state_reg == EDAC_WRITE);
	assign rd_index = sel_match(EDAC_DATA_BANK, EDAC_SEL_INDEX);
	assign rd_value = sel_match(EDAC_DATA_BANK, EDAC_SEL_VALUE);
	assign rd_flag = sel_match(EDAC_DATA_BANK, EDAC_SEL_FLAG);
	assign rd_ctrl = sel_match(EDAC_CTRL_BANK, EDAC_SEL_CTRL);

	// Upper index bits are not stored, so they read back as zero
	always_comb begin
		index_next = cell_index_reg;
		if (hit_index) begin
			index_next = reg_wdata_in[ADDR_W-1:0]; // R4
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_index_reg <= '0;
		end else begin
			cell_index_reg <= index_next;
		end
	end

	// Cycle sequencer; starts ignored while busy
	// Read start wins, when fetch_permit is set, if both starts were ever set together
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			EDAC_IDLE: begin
				if (cell_control_reg[EDAC_BIT_FSTART] && cell_control_reg[EDAC_BIT_FPERMIT]) begin
					state_next = EDAC_READ; // R6
					cnt_next = EDAC_READ_CYC;
				end else if (cell_control_reg[EDAC_BIT_PSTART]
						&& cell_control_reg[EDAC_BIT_PPERMIT]) begin
					state_next = EDAC_WRITE; // R13
					cnt_next = EDAC_WRITE_CYC;
				end
			end
			EDAC_READ, EDAC_WRITE: begin
				cnt_next = cnt_reg - 8'h01;
				if (cycle_end) begin
					state_next = EDAC_IDLE; // R18
				end
			end
			default: begin
				// Unused code recovers to idle
				state_next = EDAC_IDLE;
				cnt_next = 8'h00;
			end
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= EDAC_IDLE;
			cnt_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Store array has no reset: non-volatile contents
	always_ff @(posedge core_clk_in) begin
		if (write_end) begin
			store_mem[cell_index_reg] <= cell_value_reg; // R1 R13
		end
	end

	// A finished read wins over a same-cycle software write
	always_comb begin
		value_next = cell_value_reg;
		if (read_end) begin
			value_next = store_mem[cell_index_reg]; // R8
		end else if (hit_value) begin
			value_next = reg_wdata_in; // R9
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_value_reg <= EDAC_BYTE_RST;
		end else begin
			cell_value_reg <= value_next;
		end
	end

	// Start bits only rise via software, fall at cycle end; a start with
	// permit clear is kept, and launches a cycle once its permit is set by a write while busy or by an idle write that repeats the start
	// Permits stay writable while busy; the running cycle completes anyway
	always_comb begin
		control_next = cell_control_reg;
		if (hit_ctrl) begin
			control_next[EDAC_BIT_FPERMIT] = reg_wdata_in[EDAC_BIT_FPERMIT];
			control_next[EDAC_BIT_PPERMIT] = reg_wdata_in[EDAC_BIT_PPERMIT];
			if (!busy) begin
				control_next[EDAC_BIT_FSTART] = reg_wdata_in[EDAC_BIT_FSTART]; // R7
				control_next[EDAC_BIT_PSTART] = reg_wdata_in[EDAC_BIT_PSTART];
			end
		end
		if (read_end) begin
			control_next[EDAC_BIT_FSTART] = 1'b0; // R8
		end
		if (write_end) begin
			control_next[EDAC_BIT_PSTART] = 1'b0; // R14
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_control_reg <= EDAC_CTRL_RST[3:0]; // R15
		end else begin
			cell_control_reg <= control_next;
		end
	end

	// Set wins over a same-cycle software clear
	always_comb begin
		done_flag_next = cell_done_flag_reg;
		if (cycle_end) begin
			done_flag_next = 1'b1; // R16
		end else if (hit_flag && !reg_wdata_in[0]) begin
			done_flag_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cell_done_flag_reg <= 1'b0;
		end else begin
			cell_done_flag_reg <= done_flag_next;
		end
	end

	// Request pulse trails cycle end by one clock, same edge as the flag
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			done_req_reg <= 1'b0;
		end else begin
			done_req_reg <= cycle_end; // R16
		end
	end

	// Registered read data; unmapped selects read as zero
	always_comb begin
		rdata_next = 8'h00;
		if (rd_ctrl) begin
			rdata_next = {4'h0, cell_control_reg}; // R17
		end else if (rd_index) begin
			rdata_next = 8'(cell_index_reg); // R4
		end else if (rd_value) begin
			rdata_next = cell_value_reg;
		end else if (rd_flag) begin
			rdata_next = {7'h00, cell_done_flag_reg};
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= 8'h00;
		end else begin
			reg_rdata_out <= rdata_next;
		end
	end

	assign cell_done_flag_out = cell_done_flag_reg;
	assign cell_done_req_out = done_req_reg;
endmodule
`default_nettype wire

// [edac_core_bfm.sv]
// Purpose: core side of the register port
// Assumes: drives on falling edges
// Notes: released data is inverted
`timescale 1ns/100ps
`default_nettype none
module edac_core_bfm (
	input wire logic clk_in,
	output logic [7:0] bank_out = 8'h00,
	output logic [7:0] sel_out = 8'h00,
	output logic wr_out = 1'b0,
	output logic [7:0] wd_out = 8'h00
);
	task automatic wr(input logic [7:0] b, s, d);
		@(negedge clk_in);
		{bank_out, sel_out, wd_out, wr_out} = {b, s, d, 1'b1};
		@(negedge clk_in);
		{wd_out, wr_out} = {~d, 1'b0};
	endtask
	task automatic rd(input logic [7:0] b, s);
		@(negedge clk_in);
		{bank_out, sel_out} = {b, s};
		@(negedge clk_in);
	endtask
endmodule
`default_nettype wire

// [edac_ctrl_asserts.sv]
// Purpose: port checks for edac_ctrl
// Assumes: one clock
// Notes: busy state unseen here
`timescale 1ns/100ps
`default_nettype none
module edac_ctrl_asserts #(parameter int ADDR_W = 8) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] bank_select_in,
	input wire logic [7:0] reg_sel_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic cell_done_flag_out,
	input wire logic cell_done_req_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	wire logic b0 = bank_select_in == 8'h00;
	wire logic ctl = bank_select_in == 8'h01 && reg_sel_in == 8'h40;
	wire logic clr = reg_wr_in && b0 && reg_sel_in == 8'h02 && !reg_wdata_in[0];
	wire logic [1:0] pw = {reg_wdata_in[3], reg_wdata_in[1]};
	sequence ctl_wr_s;
		reg_wr_in && ctl ##1 ctl;
	endsequence
	ctl_hi_a: assert property (ctl |=> reg_rdata_out[7:4] == 4'h0)
		else $error("ctl hi");
	idx_hi_a: assert property (b0 && reg_sel_in == 8'h00 |=> (reg_rdata_out >> ADDR_W) == 0)
		else $error("idx hi");
	permit_a: assert property (ctl_wr_s |=> {reg_rdata_out[3], reg_rdata_out[1]} == $past(pw, 2))
		else $error("permit");
	req_flag_a: assert property (cell_done_req_out |-> cell_done_flag_out)
		else $error("req flag");
	req_one_a: assert property (cell_done_req_out |=> !cell_done_req_out)
		else $error("req long");
	flag_up_a: assert property ($rose(cell_done_flag_out) |-> cell_done_req_out)
		else $error("flag up");
	flag_keep_a: assert property (cell_done_flag_out && !clr |=> cell_done_flag_out)
		else $error("flag lost");
	flag_clr_a: assert property (clr |=> !cell_done_flag_out || cell_done_req_out)
		else $error("flag kept");
endmodule
bind edac_ctrl edac_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.core_clk_in, .rst_n_in,
	.bank_select_in, .reg_sel_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
	.cell_done_flag_out, .cell_done_req_out);
`default_nettype wire

// [tb_top.sv]
// Purpose: register-level bench for edac_ctrl
// Assumes: core model drives the port
// Notes: index cut to 5 bits to reach masking
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] bank, sel, wd, q;
	logic wr, flag, req;
	int reqs = 0;
	int failures = 0;
	int tests_run = 0;
	always #50 clk = ~clk;
	always @(posedge clk) begin
		if (req === 1'b1) begin
			reqs <= reqs + 1;
		end
	end
	edac_core_bfm core (.clk_in(clk), .bank_out(bank), .sel_out(sel), .wr_out(wr), .wd_out(wd));
	edac_ctrl #(.ADDR_W(5)) DUT (.core_clk_in(clk), .rst_n_in(rst_n), .bank_select_in(bank),
		.reg_sel_in(sel), .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(q),
		.cell_done_flag_out(flag), .cell_done_req_out(req));
	task automatic stop_test();
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] e, g, input string n);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] b, s, e, input string n);
		core.rd(b, s);
		check(e, q, n);
	endtask
	task automatic wait_clear(input int b);
		for (int i = 0; i < 40; i++) begin
			core.rd(8'h01, 8'h40);
			if (q[b] === 1'b0) return;
		end
		failures++;
		stop_test();
	endtask
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		rd(8'h01, 8'h40, 8'h00, "ctl");
		core.wr(8'h00, 8'h00, 8'hFF);
		rd(8'h00, 8'h00, 8'h1F, "idx");
		core.wr(8'h01, 8'h40, 8'h08);
		core.wr(8'h00, 8'h00, 8'h05);
		core.wr(8'h00, 8'h01, 8'hA5);
		core.wr(8'h01, 8'h40, 8'h0C);
		core.wr(8'h01, 8'h40, 8'h0A);
		core.wr(8'h01, 8'h40, 8'h0B);
		wait_clear(2);
		rd(8'h01, 8'h40, 8'h0A, "ctl");
		check(8'h01, {7'h00, flag}, "flag pin");
		check(8'h01, 8'(reqs), "req count");
		rd(8'h00, 8'h02, 8'h01, "flag");
		core.wr(8'h00, 8'h02, 8'h00);
		rd(8'h00, 8'h02, 8'h00, "flag");
		core.wr(8'h01, 8'h40, 8'h00);
		core.wr(8'h00, 8'h01, 8'h77);
		core.wr(8'h01, 8'h40, 8'h01);
		rd(8'h01, 8'h40, 8'h01, "ctl");
		rd(8'h00, 8'h02, 8'h00, "flag");
		rd(8'h00, 8'h01, 8'h77, "val");
		core.wr(8'h01, 8'h40, 8'h04);
		rd(8'h01, 8'h40, 8'h04, "ctl");
		core.wr(8'h01, 8'h40, 8'h02);
		core.wr(8'h01, 8'h40, 8'h03);
		wait_clear(0);
		rd(8'h00, 8'h01, 8'hA5, "val");
		check(8'h02, 8'(reqs), "req count");
		rd(8'h01, 8'h40, 8'h02, "ctl");
		stop_test();
	end
endmodule
`default_nettype wire
